//--- rtl/sram_defs.svh
// Constants for the synchronous flow-through SRAM bus-cycle block.
`ifndef SRAM_DEFS_SVH
`define SRAM_DEFS_SVH
`define SRAM_ADDR_W    6
`define SRAM_DEPTH     64
`define SRAM_LANES     4
`define SRAM_LANE_W    9
`define SRAM_DATA_W    36
`define SRAM_BURST_W   2
`define SRAM_BURST_ONE 2'h1
`define SRAM_BURST_ZERO 2'h0
`define SRAM_LANES_OFF 4'hF
`endif

//--- rtl/sram_pkg.sv
// Types shared by the synchronous SRAM bus-cycle block.
`include "sram_defs.svh"
package sram_pkg;
  typedef enum logic [1:0] {
    CYC_IDLE,
    CYC_READ,
    CYC_WRITE
  } cycle_t;

  typedef struct packed {
    logic                        read_not_write;
    logic                        advance_not_load;
    logic                        chip_sel_all;
    logic [`SRAM_LANES-1:0]      byte_write_n;
    logic [`SRAM_ADDR_W-1:0]     addr;
  } cmd_t;
endpackage

//--- rtl/sync_burst_sram.sv
// Synchronous flow-through SRAM core with burst counter and byte-lane writes.
// Operation
// - Low mode pin steps burst linearly.
// - Two-bit burst counter wraps every four.
// - Continue cycles advance counter before access.
// - Read begin drives data next cycle.
// - Write begin takes data next cycle.
// - Continue cycle type follows burst start.
// - Advance after deselect stays deselected.
// - Output enable high gives dummy read.
// - All byte writes high aborts write.
// - Clock enable high ignores the edge.
// - Each byte write drives its lane.
// - Any byte-write combination writes together.
// - Outputs float during write cycles.
// - Snooze ignores address and control.
// - Data outputs float after power-up.
// - High mode pin gives interleaved order.
// - Snooze high means low-power standby.
`include "sram_defs.svh"
module sync_burst_sram (
  input  wire logic                    i_clk,            // System clock.
  input  wire logic                    i_arst_n,         // Asynchronous reset, low.
  input  wire sram_pkg::cmd_t          i_cmd,            // Address and controls.
  input  wire logic                    i_clock_enable_n, // Low lets the edge act.
  input  wire logic                    i_output_enable_n,// Low lets reads drive.
  input  wire logic                    i_burst_mode,     // High interleaved, low linear.
  input  wire logic                    i_snooze_request, // High enters standby.
  input  wire logic [`SRAM_DATA_W-1:0] i_dq,             // Data bus input.
  output logic      [`SRAM_DATA_W-1:0] o_dq,             // Data bus output.
  output logic      [`SRAM_LANES-1:0]  o_dq_oe,          // Per-lane drive enable.
  output logic                         o_standby         // Standby indication.
);

  logic [`SRAM_DATA_W-1:0]  mem [`SRAM_DEPTH];
  sram_pkg::cycle_t         burst;
  sram_pkg::cycle_t         next_burst;
  logic [`SRAM_ADDR_W-1:0]  start_addr;
  logic [`SRAM_ADDR_W-1:0]  next_start_addr;
  logic [`SRAM_BURST_W-1:0] count;
  logic [`SRAM_BURST_W-1:0] next_count;
  logic                     pend_wr;
  logic                     next_pend_wr;
  logic                     pend_rd;
  logic                     next_pend_rd;
  logic [`SRAM_ADDR_W-1:0]  pend_addr;
  logic [`SRAM_ADDR_W-1:0]  next_pend_addr;
  logic [`SRAM_LANES-1:0]   pend_lanes_n;
  logic [`SRAM_LANES-1:0]   next_pend_lanes_n;
  logic [`SRAM_DATA_W-1:0]  dout;
  logic [`SRAM_DATA_W-1:0]  next_dout;
  logic                     drive;
  logic                     next_drive;
  logic                     edge_live;

  // Form the accessed address from start and counter in the chosen order.
  function automatic logic [`SRAM_ADDR_W-1:0] burst_addr(
    input logic [`SRAM_ADDR_W-1:0]  base,
    input logic [`SRAM_BURST_W-1:0] cnt,
    input logic                     interleave
  );
    logic [`SRAM_BURST_W-1:0] low;
    low = interleave ? (base[`SRAM_BURST_W-1:0] ^ cnt)
                     : (base[`SRAM_BURST_W-1:0] + cnt);
    return {base[`SRAM_ADDR_W-1:`SRAM_BURST_W], low};
  endfunction

  // Merge write data into a word lane by lane.
  function automatic logic [`SRAM_DATA_W-1:0] lane_merge(
    input logic [`SRAM_DATA_W-1:0] old_word,
    input logic [`SRAM_DATA_W-1:0] new_word,
    input logic [`SRAM_LANES-1:0]  lanes_n
  );
    logic [`SRAM_DATA_W-1:0] w;
    w = old_word;
    for (int i = 0; i < `SRAM_LANES; i++) begin
      if (!lanes_n[i]) begin
        w[i*`SRAM_LANE_W +: `SRAM_LANE_W] = new_word[i*`SRAM_LANE_W +: `SRAM_LANE_W];
      end
    end
    return w;
  endfunction

  // An edge acts only with clock enable low and no snooze; standby freezes state so a
  // write issued one cycle before snooze stays pending and completes on the next live edge.
  assign edge_live = !i_clock_enable_n && !i_snooze_request;
  assign o_standby = i_snooze_request;

  // Decode the cycle, step the burst and finish the previous cycle's transfer.
  always_comb begin
    logic [`SRAM_ADDR_W-1:0] acc_addr;
    logic                    acc_rd;
    logic                    acc_wr;
    acc_addr          = start_addr;
    acc_rd            = 1'b0;
    acc_wr            = 1'b0;
    next_burst        = burst;
    next_start_addr   = start_addr;
    next_count        = count;
    next_pend_wr      = pend_wr;
    next_pend_rd      = pend_rd;
    next_pend_addr    = pend_addr;
    next_pend_lanes_n = pend_lanes_n;
    next_dout         = dout;
    next_drive        = drive;
    if (edge_live) begin
      // Pending transfers complete even on a deselect.
      if (pend_rd) begin
        next_dout = mem[pend_addr];
      end
      if (!i_cmd.advance_not_load) begin
        if (!i_cmd.chip_sel_all) begin
          next_burst = sram_pkg::CYC_IDLE;
        end else begin
          next_burst      = i_cmd.read_not_write ? sram_pkg::CYC_READ
                                                 : sram_pkg::CYC_WRITE;
          next_start_addr = i_cmd.addr;
          next_count      = `SRAM_BURST_ZERO;
          acc_addr        = i_cmd.addr;
          acc_rd          = i_cmd.read_not_write;
          acc_wr          = !i_cmd.read_not_write;
        end
      end else if (burst != sram_pkg::CYC_IDLE) begin
        next_count = count + `SRAM_BURST_ONE;
        acc_addr   = burst_addr(start_addr, next_count, i_burst_mode);
        acc_rd     = (burst == sram_pkg::CYC_READ);
        acc_wr     = (burst == sram_pkg::CYC_WRITE);
      end
      // Idle plus advance is the continued deselect: nothing starts.
      next_pend_rd      = acc_rd && !i_output_enable_n;
      next_pend_wr      = acc_wr && (i_cmd.byte_write_n != `SRAM_LANES_OFF);
      next_pend_addr    = acc_addr;
      next_pend_lanes_n = i_cmd.byte_write_n;
      next_drive        = next_pend_rd;
    end
  end

  // Register state; the array has no reset so it writes only on live edges.
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      burst        <= sram_pkg::CYC_IDLE;
      start_addr   <= '0;
      count        <= `SRAM_BURST_ZERO;
      pend_wr      <= 1'b0;
      pend_rd      <= 1'b0;
      pend_addr    <= '0;
      pend_lanes_n <= `SRAM_LANES_OFF;
      dout         <= '0;
      drive        <= 1'b0;
    end else begin
      burst        <= next_burst;
      start_addr   <= next_start_addr;
      count        <= next_count;
      pend_wr      <= next_pend_wr;
      pend_rd      <= next_pend_rd;
      pend_addr    <= next_pend_addr;
      pend_lanes_n <= next_pend_lanes_n;
      dout         <= next_dout;
      drive        <= next_drive;
    end
  end

  // Write data arrives one cycle after its command and is stored on that edge.
  always_ff @(posedge i_clk) begin
    if (edge_live && pend_wr) begin
      mem[pend_addr] <= lane_merge(mem[pend_addr], i_dq, pend_lanes_n);
    end
  end

  // Flow-through read: data is shown in the cycle after the command.
  always_comb begin
    o_dq    = pend_rd ? mem[pend_addr] : dout;
    o_dq_oe = {`SRAM_LANES{drive}};
  end

endmodule // sync_burst_sram

//--- sim/sram_asserts.sv
// Port checks for the burst SRAM block.
module sram_asserts (
  input wire logic           i_clk,             // Clock.
  input wire logic           i_arst_n,          // Reset.
  input wire sram_pkg::cmd_t i_cmd,             // Command.
  input wire logic           i_clock_enable_n,  // Edge gate.
  input wire logic           i_output_enable_n, // Read gate.
  input wire logic           i_snooze_request,  // Standby.
  input wire logic [35:0]    o_dq,              // Read data.
  input wire logic [3:0]     o_dq_oe            // Drive.
);
  timeunit 1ns; timeprecision 1ns;
  logic live;
  // Only edges with clock enable low and no snooze may act.
  assign live = !i_clock_enable_n && !i_snooze_request;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  sequence s_load; live && !i_cmd.advance_not_load; endsequence
  sequence s_desel; live && !i_cmd.advance_not_load && !i_cmd.chip_sel_all; endsequence
  sequence s_rd; s_load ##0 (i_cmd.read_not_write && i_cmd.chip_sel_all); endsequence
  chk_read_drive: assert property (s_rd ##0 !i_output_enable_n |=> o_dq_oe == 4'hF)
    else $error("read did not drive");
  chk_dummy_read: assert property (s_rd ##0 i_output_enable_n |=> o_dq_oe == 4'h0)
    else $error("dummy read drove");
  chk_write_float: assert property (s_load ##0 !i_cmd.read_not_write |=> !o_dq_oe)
    else $error("write drove bus");
  chk_desel_float: assert property (s_desel |=> o_dq_oe == 4'h0)
    else $error("deselect drove bus");
  chk_desel_stay: assert property (s_desel ##1 (live && i_cmd.advance_not_load) |=> !o_dq_oe)
    else $error("advance after deselect drove");
  chk_edge_ignored: assert property (i_clock_enable_n |=> $stable(o_dq_oe))
    else $error("ignored edge moved drive");
  chk_snooze_hold: assert property (i_snooze_request |=> $stable(o_dq_oe))
    else $error("snooze edge moved drive");
  chk_data_hold: assert property (!live && o_dq_oe[0] |=> $stable(o_dq))
    else $error("held read data changed");
endmodule // sram_asserts
bind sync_burst_sram sram_asserts u_sram_asserts (.i_clk, .i_arst_n, .i_cmd, .i_clock_enable_n,
  .i_output_enable_n, .i_snooze_request, .o_dq, .o_dq_oe);

//--- sim/sram_master_bus.sv
// Master-side data driver and resolved data bus.
module sram_master_bus (
  input  wire logic [35:0] i_data,  // Write data.
  input  wire logic        i_drive, // Master drives.
  input  wire logic [35:0] i_dq,    // Device data.
  input  wire logic [3:0]  i_dq_oe, // Device drives.
  input  wire logic        i_clk,   // Clock.
  output logic      [35:0] o_bus    // Bus level.
);
  timeunit 1ns; timeprecision 1ns;
  logic [35:0] last;
  // A released bus shows the inverse of its last level, so a stale word never matches.
  always_ff @(posedge i_clk) last <= o_bus;
  assign o_bus = i_dq_oe[0] ? i_dq : i_drive ? i_data : ~last;
endmodule // sram_master_bus

//--- sim/testbench.sv
// Self-checking bench for the burst SRAM block.
module testbench;
  timeunit 1ns; timeprecision 1ns;
  logic i_clk = 0, i_arst_n = 0, ce_n = 1, oe_n = 0, mode = 0, zz = 0, drv = 0, sb;
  sram_pkg::cmd_t cmd = '0;
  logic [35:0] wd = '0, bus, dq, mem [64];
  logic [3:0] oe;
  int n_mismatch = 0, check_count = 0, cyc = 0;
  always #10 i_clk = ~i_clk;
  sram_master_bus u_sram_master_bus (.i_data(wd), .i_drive(drv), .i_dq(dq), .i_dq_oe(oe),
    .i_clk(i_clk), .o_bus(bus));
  sync_burst_sram u_sync_burst_sram (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_cmd(cmd),
    .i_clock_enable_n(ce_n), .i_output_enable_n(oe_n), .i_burst_mode(mode),
    .i_snooze_request(zz), .i_dq(bus), .o_dq(dq), .o_dq_oe(oe), .o_standby(sb));
  task automatic chk(input logic [35:0] got, exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Commands change at the falling edge; write data rides with the next command.
  task automatic go(input logic r, v, c, input logic [3:0] b, input logic [5:0] a,
                    input logic d, input logic [35:0] w);
    @(negedge i_clk);
    cmd = '{r, v, c, b, a};
    drv = d;
    wd = w;
  endtask
  function automatic logic [5:0] ad(logic [5:0] s, logic [1:0] i);
    return {s[5:2], mode ? s[1:0] ^ i : s[1:0] + i};
  endfunction
  // Four-word write burst, then a deselect carrying the last word.
  task automatic wburst(input logic [5:0] s, input logic [3:0] b, input logic [35:0] k);
    logic [35:0] w;
    for (int i = 0; i <= 4; i++) begin
      w = {6{ad(s, i - 1)}} ^ k;
      go(0, i > 0 && i < 4, i < 4, b, s, i > 0, w);
      for (int l = 0; l < 4; l++) if (i > 0 && !b[l]) mem[ad(s, i - 1)][9*l+:9] = w[9*l+:9];
    end
  endtask
  // Continue cycles carry write type on purpose: the burst start decides.
  task automatic rburst(input logic [5:0] s, input int n);
    for (int i = 0; i <= n; i++) begin
      go(i == 0, i > 0 && i < n, i < n, 4'h0, s, 0, 0);
      if (i > 0) chk(dq, mem[ad(s, i - 1)]);
    end
  endtask
  task automatic t_burst;
    wburst(6'h05, 4'h0, 36'h0);
    rburst(6'h05, 5);
    mode = 1;
    rburst(6'h06, 4);
    mode = 0;
    $display("burst order test done");
  endtask
  task automatic t_lanes;
    wburst(6'h04, 4'hA, 36'hF_FFFF_FFFF);
    wburst(6'h04, 4'h5, 36'h0_00FF_FF00);
    wburst(6'h04, 4'hF, 36'h1_2345_6789);
    rburst(6'h04, 4);
    $display("byte lane test done");
  endtask
  task automatic t_hold;
    // Each level set just after a command applies at that command's own edge.
    go(1, 0, 1, 4'h0, 6'h05, 0, 0);
    oe_n = 1;
    go(1, 0, 1, 4'h0, 6'h06, 0, 0);
    oe_n = 0;
    chk(oe, 4'h0);
    go(1, 0, 1, 4'h0, 6'h05, 0, 0);
    ce_n = 1;
    chk(oe, 4'hF);
    go(1, 0, 1, 4'h0, 6'h07, 0, 0);
    chk(dq, mem[6]);
    ce_n = 0;
    zz = 1;
    go(1, 0, 1, 4'h0, 6'h05, 0, 0);
    chk(dq, mem[6]);
    chk(sb, 1'b1);
    zz = 0;
    go(1, 0, 0, 4'h0, 6'h07, 0, 0);
    chk(dq, mem[5]);
    go(1, 1, 1, 4'h0, 6'h07, 0, 0);
    chk(oe, 4'h0);
    go(1, 0, 0, 4'h0, 6'h07, 0, 0);
    chk(oe, 4'h0);
    chk(sb, 1'b0);
    $display("hold and deselect test done");
  endtask
  initial begin
    repeat (16) @(posedge i_clk);
    @(negedge i_clk);
    chk(oe, 4'h0);
    i_arst_n = 1;
    ce_n = 0;
    t_burst;
    t_lanes;
    t_hold;
    wrap_up;
  end
  // A hang is cut short well past the expected run length.
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      wrap_up;
    end
  end
endmodule // testbench
